/* File: rtl/sidc_cfg.svh */
// register map, field positions and reset values of the irq/dma control block
`ifndef SIDC_CFG_SVH
`define SIDC_CFG_SVH
`define SIDC_ADDR_W       8
`define SIDC_OFS_GLOBAL   8'h04
`define SIDC_OFS_IRQ_EN   8'h08
`define SIDC_OFS_LINE_SEL 8'h0C
`define SIDC_OFS_FLAGS    8'h10
`define SIDC_BIT_FLOAT    24
`define SIDC_BIT_DMA      16
`define SIDC_BIT_GEN      24
`define SIDC_BIT_MASTER   0
`define SIDC_BIT_TX       9
`define SIDC_BIT_RX       8
`define SIDC_BIT_OVR      6
`define SIDC_BIT_BIT_MISMATCH_FLAG   4
`define SIDC_BIT_DESYNC   3
`define SIDC_BIT_PARITY   2
`define SIDC_BIT_TMO      1
`define SIDC_BIT_LEN      0
`define SIDC_SRC_MASK     10'h35F
`define SIDC_EN_MASK      32'h0101035F
`define SIDC_GLB_MASK     32'h01000001
`define SIDC_RST_REG      32'h00000000
`define SIDC_RST_SRC      10'h000
`endif

/* File: rtl/sidc_ctrl.sv */
// interrupt gating, line routing and dma requests of a serial port
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`include "sidc_cfg.svh"

// Operation
// - wait_drive_low drives wait pin low, else float enable floats it, else drive high
// - dma gate enables both dma requests
// - tx dma pulse on shift load
// - rx dma pulse on buffer copy
// - tx irq when tx enable and empty
// - tx irq rises at once if empty
// - rx irq when enable and rx full
// - overrun irq when enabled and flagged
// - bit error irq when enabled and flagged
// - desync irq enabled, master only
// - parity irq when enabled and flagged
// - timeout irq when enabled and flagged
// - length irq when enabled and flagged
// - master: early ready drop sets length fault
// - slave: early select drop sets length fault
// - tx, rx line select bits steer irqs
// - error line select bits steer irqs
// - all sources on line zero after reset
// - reserved bits read zero, ignore writes
// - tx empty set on load, cleared on write
// - rx full set on buffer copy
module sidc_ctrl
	import sidc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// events from the transfer engine, same clock
	input  wire logic        tx_shift_load,
	input  wire logic        tx_data_write,
	input  wire logic        rx_buffer_copy,
	input  wire logic        rx_buffer_read,
	input  wire logic        overrun_event,
	input  wire logic        bit_mismatch_event,
	input  wire logic        slave_desync_event,
	input  wire logic        parity_fault_event,
	input  wire logic        handshake_timeout_event,
	input  wire logic        char_active,
	input  wire logic        char_count_done,
	input  wire logic        handshake_mode,
	input  wire logic        chip_select_mode,
	input  wire logic        wait_drive_low,
	// pins
	input  wire logic        slave_ready_n_pin,
	input  wire logic        chip_select_n_pin,
	output logic             slave_ready_out,
	output logic             slave_ready_oe,
	// interrupt lines and dma requests
	output logic             irq_line_zero,
	output logic             irq_line_one,
	output logic             tx_dma_req,
	output logic             rx_dma_req,
	// status to the transfer engine
	output logic             global_transfer_enable,
	output logic             master_mode
);

	function automatic sidc_sel_t decode(input logic [31:0] a);
		case (a[`SIDC_ADDR_W-1:0])
		`SIDC_OFS_GLOBAL:   decode = SIDC_SEL_GLOBAL;
		`SIDC_OFS_IRQ_EN:   decode = SIDC_SEL_IRQ_EN;
		`SIDC_OFS_LINE_SEL: decode = SIDC_SEL_LINE;
		`SIDC_OFS_FLAGS:    decode = SIDC_SEL_FLAGS;
		default:            decode = SIDC_SEL_NONE;
		endcase
	endfunction

	logic             rst_meta;
	logic             rst_n;
	logic [1:0]       ready_sync;
	logic [1:0]       cs_sync;
	logic             ready_d;
	logic             cs_d;
	logic             next_ready_d;
	logic             next_cs_d;
	sidc_bus_t        bus_state;
	sidc_bus_t        next_bus_state;
	sidc_sel_t        bus_sel;
	sidc_sel_t        next_bus_sel;
	logic [31:0]      next_hrdata;
	logic [31:0]      glb;
	logic [31:0]      irq_en;
	logic [9:0]       line_sel;
	logic [9:0]       flags;
	logic [31:0]      next_glb;
	logic [31:0]      next_irq_en;
	logic [9:0]       next_line_sel;
	logic [9:0]       next_flags;
	logic [9:0]       set_vec;
	logic [9:0]       clr_vec;
	logic [9:0]       src_on;
	logic             len_fault;
	logic             dma_gate;
	logic             next_irq0;
	logic             next_irq1;
	logic             next_tx_dma;
	logic             next_rx_dma;
	logic             next_ready_out;
	logic             next_ready_oe;

	// every check below runs on the system clock and sleeps in reset
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pin synchronisers, index 0 is the first stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ready_sync <= 2'h3;
			cs_sync    <= 2'h3;
		end else begin
			ready_sync <= {ready_sync[0], slave_ready_n_pin};
			cs_sync    <= {cs_sync[0], chip_select_n_pin};
		end
	end

	// bus: one-cycle address phase, zero-wait data phase
	always_comb begin
		next_bus_state = SIDC_BUS_IDLE;
		next_bus_sel   = SIDC_SEL_NONE;
		next_hrdata    = hrdata;
		if (hsel && hready && htrans[1]) begin
			next_bus_sel   = decode(haddr);
			next_bus_state = hwrite ? SIDC_BUS_WRITE : SIDC_BUS_READ;
			if (!hwrite) begin
				case (decode(haddr))
				SIDC_SEL_GLOBAL: next_hrdata = glb;
				SIDC_SEL_IRQ_EN: next_hrdata = irq_en;
				SIDC_SEL_LINE:   next_hrdata = {22'h0, line_sel};
				SIDC_SEL_FLAGS:  next_hrdata = {22'h0, flags};
				default:         next_hrdata = `SIDC_RST_REG;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= SIDC_BUS_IDLE;
			bus_sel   <= SIDC_SEL_NONE;
			hrdata    <= `SIDC_RST_REG;
		end else begin
			bus_state <= next_bus_state;
			bus_sel   <= next_bus_sel;
			hrdata    <= next_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// length fault: early release of ready or select mid character
	always_comb begin
		next_ready_d = ready_sync[1];
		next_cs_d    = cs_sync[1];
		len_fault    = 1'b0;
		if (glb[`SIDC_BIT_MASTER] && handshake_mode && char_active &&
				!char_count_done && ready_sync[1] && !ready_d)
			len_fault = 1'b1;
		if (!glb[`SIDC_BIT_MASTER] && chip_select_mode && char_active &&
				!char_count_done && cs_sync[1] && !cs_d)
			len_fault = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ready_d <= 1'b1;
			cs_d    <= 1'b1;
		end else begin
			ready_d <= next_ready_d;
			cs_d    <= next_cs_d;
		end
	end

	// registers and flags; a hardware set wins over a clear
	always_comb begin
		next_glb      = glb;
		next_irq_en   = irq_en;
		next_line_sel = line_sel;
		set_vec       = `SIDC_RST_SRC;
		clr_vec       = `SIDC_RST_SRC;
		set_vec[`SIDC_BIT_TX]     = tx_shift_load;
		set_vec[`SIDC_BIT_RX]     = rx_buffer_copy;
		set_vec[`SIDC_BIT_OVR]    = overrun_event;
		set_vec[`SIDC_BIT_BIT_MISMATCH_FLAG] = bit_mismatch_event;
		set_vec[`SIDC_BIT_DESYNC] = slave_desync_event;
		set_vec[`SIDC_BIT_PARITY] = parity_fault_event;
		set_vec[`SIDC_BIT_TMO]    = handshake_timeout_event;
		set_vec[`SIDC_BIT_LEN]    = len_fault;
		clr_vec[`SIDC_BIT_TX]     = tx_data_write;
		clr_vec[`SIDC_BIT_RX]     = rx_buffer_read;
		if (bus_state == SIDC_BUS_WRITE) begin
			case (bus_sel)
			SIDC_SEL_GLOBAL: next_glb = hwdata & `SIDC_GLB_MASK;
			SIDC_SEL_IRQ_EN: next_irq_en = hwdata & `SIDC_EN_MASK;
			SIDC_SEL_LINE:   next_line_sel = hwdata[9:0] & `SIDC_SRC_MASK;
			SIDC_SEL_FLAGS:  clr_vec = clr_vec | (hwdata[9:0] & `SIDC_SRC_MASK);
			default:         next_glb = glb;
			endcase
		end
		next_flags = (flags & ~clr_vec) | set_vec;
		if (!glb[`SIDC_BIT_GEN])
			next_flags = `SIDC_RST_SRC;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			glb      <= `SIDC_RST_REG;
			irq_en   <= `SIDC_RST_REG;
			line_sel <= `SIDC_RST_SRC;
			flags    <= `SIDC_RST_SRC;
		end else begin
			glb      <= next_glb;
			irq_en   <= next_irq_en;
			line_sel <= next_line_sel;
			flags    <= next_flags;
		end
	end

	assign global_transfer_enable = glb[`SIDC_BIT_GEN];
	assign master_mode            = glb[`SIDC_BIT_MASTER];
	assign dma_gate               = irq_en[`SIDC_BIT_DMA];

	// per-source gating; desync only counts as master
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_src
			if (gi == `SIDC_BIT_DESYNC) begin : g_ds
				assign src_on[gi] = flags[gi] && irq_en[gi] &&
						glb[`SIDC_BIT_MASTER];
			end else begin : g_pl
				assign src_on[gi] = flags[gi] && irq_en[gi];
			end
		end
	endgenerate

	// routing, dma pulses and the wait pin
	always_comb begin
		next_irq0   = |(src_on & ~line_sel);
		next_irq1   = |(src_on & line_sel);
		next_tx_dma = dma_gate && tx_shift_load;
		next_rx_dma = dma_gate && rx_buffer_copy;
		next_ready_out = 1'b1;
		next_ready_oe  = 1'b1;
		if (wait_drive_low)
			next_ready_out = 1'b0;
		else if (irq_en[`SIDC_BIT_FLOAT])
			next_ready_oe = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_line_zero   <= 1'b0;
			irq_line_one    <= 1'b0;
			tx_dma_req      <= 1'b0;
			rx_dma_req      <= 1'b0;
			slave_ready_out <= 1'b1;
			slave_ready_oe  <= 1'b1;
		end else begin
			irq_line_zero   <= next_irq0;
			irq_line_one    <= next_irq1;
			tx_dma_req      <= next_tx_dma;
			rx_dma_req      <= next_rx_dma;
			slave_ready_out <= next_ready_out;
			slave_ready_oe  <= next_ready_oe;
		end
	end

	sequence s_tx_load_gated;
		tx_shift_load && dma_gate;
	endsequence

	sequence s_rx_copy_gated;
		rx_buffer_copy && dma_gate;
	endsequence

	chk_tx_dma_pulse: assert property (
		s_tx_load_gated |=> tx_dma_req)
		else $error("tx dma request missing after shift load");

	chk_rx_dma_pulse: assert property (
		s_rx_copy_gated |=> rx_dma_req)
		else $error("rx dma request missing after buffer copy");

	chk_dma_gate_off: assert property (
		!dma_gate |=> !tx_dma_req && !rx_dma_req)
		else $error("dma request while gate is off");

	chk_tx_empty_set: assert property (
		tx_shift_load && glb[`SIDC_BIT_GEN] |=> flags[`SIDC_BIT_TX])
		else $error("tx empty flag not set on shift load");

	chk_rx_full_set: assert property (
		rx_buffer_copy && glb[`SIDC_BIT_GEN] |=> flags[`SIDC_BIT_RX])
		else $error("rx full flag not set on copy");

	chk_tx_irq_route: assert property (
		flags[`SIDC_BIT_TX] && irq_en[`SIDC_BIT_TX] |=>
		(line_sel[`SIDC_BIT_TX] ? irq_line_one : irq_line_zero) ||
		$changed(line_sel))
		else $error("tx irq not on its selected line");

	chk_line_or: assert property (
		1'b1 |=> irq_line_one == $past(|(src_on & line_sel)))
		else $error("line one differs from routed sources");

	chk_desync_slave: assert property (
		!glb[`SIDC_BIT_MASTER] && !(|(src_on & ~`SIDC_SRC_MASK)) &&
		(flags & irq_en[9:0] & ~10'h008) == 10'h000 |=> !irq_line_zero)
		else $error("desync irq raised outside master mode");

	chk_float_pin: assert property (
		irq_en[`SIDC_BIT_FLOAT] && !wait_drive_low ##1
		$stable(irq_en) |-> !slave_ready_oe)
		else $error("wait pin driven while float enabled");

	chk_len_master: assert property (
		len_fault && glb[`SIDC_BIT_GEN] |=> flags[`SIDC_BIT_LEN])
		else $error("length fault not flagged");

	chk_reserved_zero: assert property (
		(irq_en & ~`SIDC_EN_MASK) == `SIDC_RST_REG)
		else $error("reserved enable bits set");

endmodule

/* File: rtl/sidc_pkg.sv */
// types shared by the irq/dma control block
package sidc_pkg;
	typedef enum logic [2:0] {
		SIDC_SEL_NONE,
		SIDC_SEL_GLOBAL,
		SIDC_SEL_IRQ_EN,
		SIDC_SEL_LINE,
		SIDC_SEL_FLAGS
	} sidc_sel_t;
	typedef enum {
		SIDC_BUS_IDLE,
		SIDC_BUS_WRITE,
		SIDC_BUS_READ
	} sidc_bus_t;
endpackage

/* File: testbench/sidc_far_model.sv */
// stand-in for the cpu interrupt controller and the system dma controller
`timescale 1ns/10ps
module sidc_far_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// requests from the block
	input  wire logic       irq_line_zero,
	input  wire logic       irq_line_one,
	input  wire logic       tx_dma_req,
	input  wire logic       rx_dma_req,
	// what was serviced
	output logic      [7:0] tx_dma_count,
	output logic      [7:0] rx_dma_count,
	output logic      [1:0] irq_seen
);
	// every cycle a request stands high is one serviced transfer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_dma_count <= 8'h00;
			rx_dma_count <= 8'h00;
			irq_seen     <= 2'h0;
		end else begin
			tx_dma_count <= tx_dma_count + {7'h00, tx_dma_req};
			rx_dma_count <= rx_dma_count + {7'h00, rx_dma_req};
			irq_seen     <= {irq_line_one, irq_line_zero};
		end
	end
endmodule

/* File: testbench/spi_interrupt_dma_request_ctrl_tb_top.sv */
// self-checking bench of the irq/dma control block
`timescale 1ns/10ps
module spi_interrupt_dma_request_ctrl_tb_top;
	logic        clk_sys, arst_n, hwrite, hs, cmd, cad, wlo, rdy_n;
	logic        tdw, csn, ccd;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        hreadyout, hresp, sro, soe, l0, l1, txd, rxd, gen, mst;
	logic [6:0]  ev;
	logic [7:0]  txc, rxc;
	logic [1:0]  seen;
	logic [25:0] rows [0:10];
	int          fails, cmp_count, i;
	sidc_ctrl sidc_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.hsel(htrans[1]), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tx_shift_load(ev[0]),
		.tx_data_write(tdw), .rx_buffer_copy(ev[1]), .rx_buffer_read(1'b0),
		.overrun_event(ev[2]), .bit_mismatch_event(ev[3]),
		.slave_desync_event(ev[4]), .parity_fault_event(ev[5]),
		.handshake_timeout_event(ev[6]), .char_active(cad),
		.char_count_done(ccd), .handshake_mode(hs),
		.chip_select_mode(cmd), .wait_drive_low(wlo),
		.slave_ready_n_pin(rdy_n), .chip_select_n_pin(csn),
		.slave_ready_out(sro), .slave_ready_oe(soe), .irq_line_zero(l0),
		.irq_line_one(l1), .tx_dma_req(txd), .rx_dma_req(rxd),
		.global_transfer_enable(gen), .master_mode(mst));
	sidc_far_model sidc_far_model_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.irq_line_zero(l0), .irq_line_one(l1), .tx_dma_req(txd),
		.rx_dma_req(rxd), .tx_dma_count(txc), .rx_dma_count(rxc),
		.irq_seen(seen));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr  <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge clk_sys);
		ev <= 7'h00;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk_sys);
		fails++;
		results();
	end
	initial begin
		// event, lines {one,zero}, enables, line select
		rows = '{{4'd0, 2'b01, 10'h200, 10'h000}, {4'd0, 2'b10, 10'h200, 10'h200},
			{4'd0, 2'b00, 10'h000, 10'h000}, {4'd1, 2'b10, 10'h100, 10'h100},
			{4'd1, 2'b00, 10'h000, 10'h000}, {4'd2, 2'b01, 10'h040, 10'h000},
			{4'd3, 2'b10, 10'h010, 10'h010}, {4'd4, 2'b10, 10'h008, 10'h008},
			{4'd5, 2'b01, 10'h004, 10'h000}, {4'd6, 2'b10, 10'h002, 10'h002},
			{4'd6, 2'b00, 10'h000, 10'h000}};
		fails = 0;
		cmp_count = 0;
		{hwrite, hs, cmd, cad, wlo, ev, tdw, ccd} = '0;
		{htrans, haddr, hwdata} = '0;
		{rdy_n, csn} = 2'h3;
		arst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check({30'h0, l1, l0, sro, soe}, 32'h3);
		bus(1'b0, 8'h0C, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, 8'h04, 32'h01000001);
		bus(1'b1, 8'h08, 32'hFFFFFFFF);
		bus(1'b1, 8'h0C, 32'hFFFFFFFF);
		bus(1'b0, 8'h08, 32'h0);
		check(rd, 32'h0101035F);
		bus(1'b0, 8'h0C, 32'h0);
		check(rd, 32'h0000035F);
		bus(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0);
		check({29'h0, hresp, gen, mst}, 32'h3);
		for (i = 0; i < 11; i++) begin
			bus(1'b1, 8'h08, 32'h0);
			bus(1'b1, 8'h10, 32'h35F);
			bus(1'b1, 8'h0C, {22'h0, rows[i][9:0]});
			bus(1'b1, 8'h08, {22'h0, rows[i][19:10]});
			pulse(rows[i][25:22]);
			check({30'h0, seen}, {30'h0, rows[i][21:20]});
		end
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b1, 8'h10, 32'h35F);
		bus(1'b1, 8'h08, 32'h200);
		repeat (3) @(posedge clk_sys);
		check({31'h0, l0}, 32'h0);
		pulse(0);
		bus(1'b1, 8'h08, 32'h0);
		repeat (4) @(posedge clk_sys);
		check({31'h0, l0}, 32'h0);
		bus(1'b1, 8'h08, 32'h200);
		repeat (3) @(posedge clk_sys);
		check({31'h0, l0}, 32'h1);
		// a write of new transmit data empties the flag again
		tdw <= 1'b1;
		@(posedge clk_sys);
		tdw <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check({31'h0, l0}, 32'h0);
		bus(1'b1, 8'h08, 32'h10000);
		pulse(0);
		pulse(1);
		check({16'h0, txc, rxc}, 32'h0101);
		bus(1'b1, 8'h08, 32'h0);
		pulse(0);
		pulse(1);
		check({16'h0, txc, rxc}, 32'h0101);
		bus(1'b1, 8'h10, 32'h35F);
		bus(1'b1, 8'h08, 32'h1);
		hs <= 1'b1;
		cad <= 1'b1;
		rdy_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rdy_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		bus(1'b0, 8'h10, 32'h0);
		check(rd, 32'h1);
		check({31'h0, l0}, 32'h1);
		bus(1'b1, 8'h08, 32'h01000000);
		repeat (2) @(negedge clk_sys);
		check({31'h0, soe}, 32'h0);
		wlo <= 1'b1;
		repeat (2) @(negedge clk_sys);
		check({30'h0, sro, soe}, 32'h1);
		bus(1'b1, 8'h08, 32'h0);
		wlo <= 1'b0;
		repeat (2) @(negedge clk_sys);
		check({30'h0, sro, soe}, 32'h3);
		// desync source is held off the lines outside master mode
		bus(1'b1, 8'h04, 32'h01000000);
		bus(1'b1, 8'h10, 32'h35F);
		check({29'h0, hresp, gen, mst}, 32'h2);
		bus(1'b1, 8'h08, 32'h8);
		pulse(4);
		check({30'h0, seen}, 32'h0);
		bus(1'b1, 8'h04, 32'h01000001);
		repeat (3) @(posedge clk_sys);
		check({31'h0, l0}, 32'h1);
		// slave: select released mid character, then after the count
		bus(1'b1, 8'h04, 32'h01000000);
		bus(1'b1, 8'h10, 32'h35F);
		bus(1'b1, 8'h08, 32'h1);
		cmd <= 1'b1;
		csn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check({31'h0, l0}, 32'h0);
		csn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		check({31'h0, l0}, 32'h1);
		bus(1'b1, 8'h10, 32'h35F);
		ccd <= 1'b1;
		csn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		csn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		check({31'h0, l0}, 32'h0);
		results();
	end
endmodule
